// >>> src/mof_pkg.sv
// constants, types and carriers for the main oscillator control block
// assumes one 20 MHz reference clock and clocks that arrive as pin levels
//
// What this block does
// - after reset the oscillator stays off and the system runs from the slow clock.
// - clearing the enable stops the oscillator and clears the stable flag at once.
// - a write setting the enable clears the stable flag and loads the slow/8 down-counter.
// - the start-up count is eight bits wide, bounding the longest start-up wait.
// - a slow/8 tick with the down-counter already at zero sets the stable flag, raising an interrupt if masked in.
// - once stable, the meter counts main clock cycles from the next slow clock rise.
// - on the 16th slow clock fall the meter stops and sets its ready bit.
// - the final meter value is readable and equals main cycles in 15.5 slow periods, from the slow rise to the 16th fall.
// - the generator outputs the slow, main oscillator and both pll clocks.
package mof_pkg;

	// reference clock and derived figures
	localparam int REF_CLK_HZ        = 20000000;
	localparam int REF_PERIOD_NS     = 1000000000 / REF_CLK_HZ;

	// field widths
	localparam int STARTUP_CNT_W     = 8;
	localparam int FREQ_CNT_W        = 16;
	localparam int SLOW_DIV_W        = 3;
	localparam int FALL_CNT_W        = 5;

	// timing counts
	localparam logic [SLOW_DIV_W-1:0] SLOW_DIV_LAST  = 3'h7; // slow clock / 8
	localparam logic [FALL_CNT_W-1:0] MEAS_FALL_LAST = 5'h0f; // 16th fall

	// reset values and the meter saturation limit
	localparam logic [STARTUP_CNT_W-1:0] STARTUP_CNT_RST = 8'h00;
	localparam logic [FREQ_CNT_W-1:0]    FREQ_CNT_RST    = 16'h0000;
	localparam logic [FREQ_CNT_W-1:0]    FREQ_CNT_MAX    = 16'hffff;

	// indices of the sampled clock pins
	localparam int PIN_SLOW   = 0;
	localparam int PIN_MAIN   = 1;
	localparam int PIN_XTAL   = 2;
	localparam int PIN_PLL_A  = 3;
	localparam int PIN_PLL_B  = 4;
	localparam int PIN_COUNT  = 5;

	// frequency meter phases
	typedef enum logic [1:0] {
		MEAS_IDLE,
		MEAS_WAIT_RISE,
		MEAS_COUNT,
		MEAS_DONE
	} mof_meas_t;

	// clock outputs of the generator
	typedef struct packed {
		logic slow_clock;
		logic main_osc_clock;
		logic pll_a_clock;
		logic pll_b_clock;
	} mof_clk_out_t;

	// whole state of the control block
	typedef struct packed {
		logic                     osc_en;
		logic                     bypass;
		logic                     counting;
		logic [STARTUP_CNT_W-1:0] startup_cnt;
		logic [SLOW_DIV_W-1:0]    div_cnt;
		logic                     stable;
		logic                     stable_irq;
		logic                     ready;
		mof_meas_t                meas;
		logic [FALL_CNT_W-1:0]    fall_cnt;
		logic [FREQ_CNT_W-1:0]    freq_cnt;
		logic                     on_slow;
		mof_clk_out_t             clk_out;
	} mof_state_t;

endpackage : mof_pkg

// >>> src/mof_sync.sv
// two-flop synchroniser with edge detection for one pin level
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
module mof_sync (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// pin in
	input  wire logic pin_in,
	// synchronised level and edges
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// first flop feeds only the second one
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// edges from the settled stages only
	assign level = sync_reg;
	assign rise  = sync_reg & ~prev_reg;
	assign fall  = ~sync_reg & prev_reg;
endmodule : mof_sync
`default_nettype wire

// >>> src/mof_top.sv
// main oscillator enable, start-up countdown and frequency meter
// assumes control inputs come from logic on ref_clk; clocks come from pins
`timescale 1ns/10ps
`default_nettype none
module mof_top
	import mof_pkg::*;
(
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     reset,
	// control write from software
	input  wire logic                     ctrl_write,
	input  wire logic                     main_osc_enable,
	input  wire logic                     osc_bypass_select,
	input  wire logic [STARTUP_CNT_W-1:0] osc_startup_count,
	input  wire logic                     stable_irq_mask,
	// clock pins
	input  wire logic                     slow_clock,
	input  wire logic                     main_osc_clock,
	input  wire logic                     osc_input_pin,
	input  wire logic                     pll_a_clock,
	input  wire logic                     pll_b_clock,
	// status
	output logic                          main_osc_stable_flag,
	output logic                          stable_irq,
	output logic                          freq_measure_ready,
	output logic [FREQ_CNT_W-1:0]         main_freq_count,
	output logic                          osc_power_on,
	output logic                          sys_on_slow_clock,
	// generated clocks
	output mof_clk_out_t                  clk_out
);
	mof_state_t st_reg;
	mof_state_t st_next;

	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_lvl;
	logic [PIN_COUNT-1:0] pin_rise;
	logic [PIN_COUNT-1:0] pin_fall;
	logic                 slow_tick;
	logic                 src_rise;
	logic                 src_lvl;

	// every clock pin is brought into ref_clk before use
	assign pin_raw[PIN_SLOW]  = slow_clock;
	assign pin_raw[PIN_MAIN]  = main_osc_clock;
	assign pin_raw[PIN_XTAL]  = osc_input_pin;
	assign pin_raw[PIN_PLL_A] = pll_a_clock;
	assign pin_raw[PIN_PLL_B] = pll_b_clock;

	// one synchroniser per pin
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
			mof_sync u_sync (
				.ref_clk (ref_clk),
				.reset   (reset),
				.pin_in  (pin_raw[gi]),
				.level   (pin_lvl[gi]),
				.rise    (pin_rise[gi]),
				.fall    (pin_fall[gi])
			);
		end
	endgenerate

	// slow clock divided by eight as a one-cycle enable
	assign slow_tick = pin_rise[PIN_SLOW] && (st_reg.div_cnt == SLOW_DIV_LAST);

	// main clock source: pin in bypass, oscillator otherwise; sampled at
	// 20 MHz so the meter only resolves main clocks below 10 MHz
	assign src_rise = st_reg.bypass ? pin_rise[PIN_XTAL] : pin_rise[PIN_MAIN];
	assign src_lvl  = st_reg.bypass ? pin_lvl[PIN_XTAL] : pin_lvl[PIN_MAIN];

	// next state
	always_comb begin
		st_next = st_reg;

		// divider runs freely on slow clock rises
		if (pin_rise[PIN_SLOW]) begin
			st_next.div_cnt = st_reg.div_cnt + 3'h1;
		end

		// start-up countdown on slow / 8
		if (st_reg.counting && slow_tick) begin
			if (st_reg.startup_cnt == STARTUP_CNT_RST) begin
				st_next.counting = 1'b0;
				st_next.stable   = 1'b1;
			end else begin
				st_next.startup_cnt = st_reg.startup_cnt - 8'h01;
			end
		end

		// frequency meter
		case (st_reg.meas)
			MEAS_IDLE: begin
				if (st_reg.stable && !st_reg.ready) begin
					st_next.meas = MEAS_WAIT_RISE;
				end
			end
			MEAS_WAIT_RISE: begin
				if (pin_rise[PIN_SLOW]) begin
					st_next.meas     = MEAS_COUNT;
					st_next.freq_cnt = FREQ_CNT_RST;
					st_next.fall_cnt = '0;
				end
			end
			MEAS_COUNT: begin
				// saturate rather than wrap on a fast source
				if (src_rise && st_reg.freq_cnt != FREQ_CNT_MAX) begin
					st_next.freq_cnt = st_reg.freq_cnt + 16'h0001;
				end
				if (pin_fall[PIN_SLOW]) begin
					if (st_reg.fall_cnt == MEAS_FALL_LAST) begin
						st_next.meas  = MEAS_DONE;
						st_next.ready = 1'b1;
					end else begin
						st_next.fall_cnt = st_reg.fall_cnt + 5'h01;
					end
				end
			end
			MEAS_DONE: begin
				st_next.meas = MEAS_DONE; // value held for reading
			end
			default: begin
				st_next.meas = MEAS_IDLE;
			end
		endcase

		// software write overrides the countdown in the same cycle
		if (ctrl_write) begin
			st_next.osc_en = main_osc_enable;
			st_next.bypass = osc_bypass_select;
			st_next.stable = 1'b0;
			if (main_osc_enable) begin
				st_next.counting    = 1'b1;
				st_next.startup_cnt = osc_startup_count;
			end else begin
				st_next.counting = 1'b0;
				st_next.ready    = 1'b0;
				st_next.meas     = MEAS_IDLE;
			end
		end

		// system stays on the slow clock until the oscillator is valid
		st_next.on_slow    = !st_next.stable;
		st_next.stable_irq = st_reg.stable && stable_irq_mask;

		// generated clocks, main gated off while disabled and not in bypass
		st_next.clk_out.slow_clock     = pin_lvl[PIN_SLOW];
		st_next.clk_out.main_osc_clock = src_lvl &&
			(st_reg.osc_en || st_reg.bypass);
		st_next.clk_out.pll_a_clock    = pin_lvl[PIN_PLL_A];
		st_next.clk_out.pll_b_clock    = pin_lvl[PIN_PLL_B];
	end

	// state register; oscillator off after reset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_reg             <= '0;
			st_reg.startup_cnt <= STARTUP_CNT_RST;
			st_reg.freq_cnt    <= FREQ_CNT_RST;
			st_reg.meas        <= MEAS_IDLE;
			st_reg.on_slow     <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	assign main_osc_stable_flag = st_reg.stable;
	assign stable_irq           = st_reg.stable_irq;
	assign freq_measure_ready   = st_reg.ready;
	assign main_freq_count      = st_reg.freq_cnt;
	assign osc_power_on         = st_reg.osc_en;
	assign sys_on_slow_clock    = st_reg.on_slow;
	assign clk_out              = st_reg.clk_out;

	// checks
	a_off_after_reset: assert property (@(posedge ref_clk)
		$fell(reset) |-> !osc_power_on && sys_on_slow_clock)
		else $error("oscillator not off after reset");

	a_disable_clears: assert property (@(posedge ref_clk) disable iff (reset)
		ctrl_write && !main_osc_enable |=> !main_osc_stable_flag && !osc_power_on)
		else $error("disable did not clear stable flag");

	a_enable_loads: assert property (@(posedge ref_clk) disable iff (reset)
		ctrl_write && main_osc_enable |=>
			!main_osc_stable_flag && st_reg.counting &&
			st_reg.startup_cnt == $past(osc_startup_count))
		else $error("enable did not load start-up count");

	a_count_decrement: assert property (@(posedge ref_clk) disable iff (reset)
		!ctrl_write && st_reg.counting && slow_tick &&
		st_reg.startup_cnt != 8'h00 |=>
			st_reg.startup_cnt == $past(st_reg.startup_cnt) - 8'h01)
		else $error("start-up count not decremented");

	a_stable_set: assert property (@(posedge ref_clk) disable iff (reset)
		!ctrl_write && st_reg.counting && slow_tick &&
		st_reg.startup_cnt == 8'h00 |=> main_osc_stable_flag ##1 
			(stable_irq == $past(stable_irq_mask)))
		else $error("stable flag or interrupt missing");

	a_meter_start: assert property (@(posedge ref_clk) disable iff (reset)
		!ctrl_write && st_reg.meas == MEAS_WAIT_RISE && pin_rise[PIN_SLOW] |=>
			st_reg.meas == MEAS_COUNT && main_freq_count == 16'h0000)
		else $error("meter did not start on slow rise");

	a_ready_16th: assert property (@(posedge ref_clk) disable iff (reset)
		!ctrl_write && st_reg.meas == MEAS_COUNT && pin_fall[PIN_SLOW] |=>
			freq_measure_ready == ($past(st_reg.fall_cnt) == MEAS_FALL_LAST))
		else $error("ready not on 16th slow fall");

	a_value_held: assert property (@(posedge ref_clk) disable iff (reset)
		freq_measure_ready |=> $stable(main_freq_count))
		else $error("meter value moved after ready");

	a_ready_cleared: assert property (@(posedge ref_clk) disable iff (reset)
		ctrl_write && !main_osc_enable |=> !freq_measure_ready)
		else $error("ready not cleared on disable");

	c_startup_done: cover property (@(posedge ref_clk) disable iff (reset)
		$rose(main_osc_stable_flag));
	c_measure_done: cover property (@(posedge ref_clk) disable iff (reset)
		$rose(freq_measure_ready));
	c_irq_raised: cover property (@(posedge ref_clk) disable iff (reset)
		$rose(stable_irq));
endmodule : mof_top
`default_nettype wire

// >>> bench/mof_bench.sv
// bench for the main oscillator control block, self-checking
// assumes mof_top alone; pin clocks are made here from ref_clk counts
`timescale 1ns/10ps
`default_nettype none
module mof_bench;
	import mof_pkg::*;
	// one row: control write beside the outcome it should give
	typedef struct packed {
		logic       en;
		logic       byp;
		logic [7:0] cnt;
		logic       msk;
		logic       st;
		logic       irq;
	} mof_row_t;
	logic                  ref_clk, reset, ctrl_write, main_osc_enable;
	logic                  osc_bypass_select, stable_irq_mask;
	logic [STARTUP_CNT_W-1:0] osc_startup_count;
	logic                  slow_clock, main_osc_clock, osc_input_pin;
	logic                  pll_a_clock, pll_b_clock;
	logic                  main_osc_stable_flag, stable_irq;
	logic                  freq_measure_ready, osc_power_on;
	logic                  sys_on_slow_clock;
	logic [FREQ_CNT_W-1:0] main_freq_count;
	mof_clk_out_t          clk_out;
	int                    bad_count, checks, pc, n, t;
	mof_row_t              r;
	mof_row_t              rows [4] = '{
		'{1'h1, 1'h0, 8'h00, 1'h1, 1'h1, 1'h1},
		'{1'h1, 1'h0, 8'h03, 1'h0, 1'h1, 1'h0},
		'{1'h1, 1'h0, 8'h01, 1'h1, 1'h1, 1'h1},
		'{1'h0, 1'h1, 8'h02, 1'h1, 1'h0, 1'h0}};

	mof_top i_dut (
		.ref_clk(ref_clk), .reset(reset), .ctrl_write(ctrl_write),
		.main_osc_enable(main_osc_enable),
		.osc_bypass_select(osc_bypass_select),
		.osc_startup_count(osc_startup_count),
		.stable_irq_mask(stable_irq_mask), .slow_clock(slow_clock),
		.main_osc_clock(main_osc_clock), .osc_input_pin(osc_input_pin),
		.pll_a_clock(pll_a_clock), .pll_b_clock(pll_b_clock),
		.main_osc_stable_flag(main_osc_stable_flag),
		.stable_irq(stable_irq), .freq_measure_ready(freq_measure_ready),
		.main_freq_count(main_freq_count), .osc_power_on(osc_power_on),
		.sys_on_slow_clock(sys_on_slow_clock), .clk_out(clk_out));

	// 50 ns reference clock
	always #25 ref_clk = ~ref_clk;

	// pins from a cycle count: slow is 20 cycles, main 4, osc pin 6
	always @(negedge ref_clk) begin
		pc++;
		slow_clock = (pc % 20) < 10;
		main_osc_clock = pc[1];
		osc_input_pin = (pc % 6) < 3;
		pll_a_clock = pc[2];
		pll_b_clock = pc[3];
		// whole run needs well under this many cycles
		if (pc > 30000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %b exp %b", $time, got, exp);
		end
	endtask : chk_bit

	// meter value lies in a band: edge sampling blurs both ends
	task automatic chk_rng(input logic [FREQ_CNT_W-1:0] got, input int lo,
		input int hi);
		checks++;
		if (^got === 1'bx || got < lo || got > hi) begin
			bad_count++;
			$display("MISMATCH t=%0t meter %0d", $time, got);
		end
	endtask : chk_rng

	// one-cycle control write, fields held with the strobe
	task automatic wr(input logic en, byp, input logic [7:0] c,
		input logic m);
		main_osc_enable = en;
		osc_bypass_select = byp;
		osc_startup_count = c;
		stable_irq_mask = m;
		ctrl_write = 1'h1;
		@(negedge ref_clk);
		ctrl_write = 1'h0;
	endtask : wr

	// toggles of one clock copy over 40 cycles
	task automatic tog(input int k, output int cnt);
		logic last;
		cnt = 0;
		last = clk_out[k];
		repeat (40) begin
			@(negedge ref_clk);
			if (clk_out[k] !== last)
				cnt++;
			last = clk_out[k];
		end
	endtask : tog

	task automatic report_and_stop();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	initial begin
		{ref_clk, ctrl_write, main_osc_enable, osc_bypass_select} = '0;
		{osc_startup_count, stable_irq_mask} = '0;
		{slow_clock, main_osc_clock, osc_input_pin} = '0;
		{pll_a_clock, pll_b_clock, bad_count, checks, pc} = '0;
		reset = 1'h1;
		repeat (4) @(negedge ref_clk);
		reset = 1'h0;
		@(negedge ref_clk);
		// table rows: start-up wait, interrupt, meter, disable
		for (int i = 0; i < 4; i++) begin
			r = rows[i];
			wr(r.en, r.byp, r.cnt, r.msk);
			chk_bit(main_osc_stable_flag, 1'h0);
			chk_bit(osc_power_on, r.en);
			n = 0;
			while (main_osc_stable_flag !== 1'h1 && n < (r.st ? 900 : 400))
			begin
				@(negedge ref_clk);
				n++;
			end
			chk_bit(main_osc_stable_flag, r.st);
			if (r.st) begin
				chk_bit(n + 2 >= r.cnt * 160, 1'h1);
				chk_bit(n <= (r.cnt + 1) * 160 + 8, 1'h1);
				@(negedge ref_clk);
				chk_bit(stable_irq, r.irq);
				chk_bit(sys_on_slow_clock, 1'h0);
				n = 0;
				while (freq_measure_ready !== 1'h1 && n < 400) begin
					@(negedge ref_clk);
					n++;
				end
				chk_bit(freq_measure_ready, 1'h1);
				chk_rng(main_freq_count, 75, 81);
			end
			wr(1'h0, 1'h0, 8'h00, r.msk);
			chk_bit(main_osc_stable_flag, 1'h0);
			chk_bit(freq_measure_ready, 1'h0);
			@(negedge ref_clk);
			chk_bit(sys_on_slow_clock, 1'h1);
			$display("row %0d done", i);
		end
		// rewrite while stable restarts the sequence
		wr(1'h1, 1'h0, 8'h00, 1'h1);
		repeat (180) @(negedge ref_clk);
		chk_bit(main_osc_stable_flag, 1'h1);
		wr(1'h1, 1'h0, 8'h02, 1'h1);
		chk_bit(main_osc_stable_flag, 1'h0);
		$display("restart done");
		// reset in mid-run returns to the off state
		reset = 1'h1;
		@(negedge ref_clk);
		chk_bit(osc_power_on, 1'h0);
		chk_bit(sys_on_slow_clock, 1'h1);
		reset = 1'h0;
		@(negedge ref_clk);
		chk_bit(main_osc_stable_flag, 1'h0);
		chk_bit(clk_out.main_osc_clock, 1'h0);
		$display("reset done");
		// clock copies: gated when off, external pin in bypass
		tog(2, t);
		chk_bit(t == 0, 1'h1);
		wr(1'h0, 1'h1, 8'h00, 1'h0);
		tog(3, t);
		chk_bit(t >= 3, 1'h1);
		tog(2, t);
		chk_bit(t >= 11 && t <= 15, 1'h1);
		tog(1, t);
		chk_bit(t >= 9, 1'h1);
		tog(0, t);
		chk_bit(t >= 4, 1'h1);
		chk_bit(main_osc_stable_flag, 1'h0);
		$display("clock outputs done");
		report_and_stop();
	end
endmodule : mof_bench
`default_nettype wire
